// file: include/rfb_pkg.sv
// Purpose: shared constants and types of the receive frame store
// Assumes: one clock domain, pointers wide enough for the largest RAM
// Notes:   frame length lives in a small field of the metadata word

package rfb_pkg;

  // widths
  localparam int AW = 12;                      // pointer width, covers 4096 words
  localparam int CW = 13;                      // word and frame counters, holds 4096
  localparam int DW = 32;                      // RAM word width
  localparam int WCNT_W = 5;                   // width of words-after-metadata field

  // RAM depth limits and default
  localparam int DEPTH_MIN = 32;
  localparam int DEPTH_MAX = 4096;
  localparam int DEPTH_DEF = 32;

  // metadata field that tells the reader how many words follow it
  localparam int WCNT_LSB = 0;

  // header sequence: metadata, identifier, upper stamp, lower stamp
  localparam logic [1:0] STEP_IDENT = 2'h1;
  localparam logic [1:0] STEP_TS_LO = 2'h3;

  // values after reset
  localparam logic [AW-1:0] PTR_RST = 12'h000;
  localparam logic [CW-1:0] CNT_RST = 13'h0000;
  localparam logic [DW-1:0] WORD_ZERO = 32'h00000000;

  typedef logic [AW-1:0] rfb_ptr_type;
  typedef logic [CW-1:0] rfb_cnt_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_META  = 4'h2,
    ST_STORE = 4'h4,
    ST_TS_LO = 4'h8
  } rfb_state_type;

  // step forward around the ring
  function automatic rfb_ptr_type ptr_inc(input rfb_ptr_type p, input rfb_ptr_type last);
    ptr_inc = (p == last) ? PTR_RST : p + 12'h001;
  endfunction : ptr_inc

  // step back around the ring
  function automatic rfb_ptr_type ptr_dec(input rfb_ptr_type p, input rfb_ptr_type last);
    ptr_dec = (p == PTR_RST) ? last : p - 12'h001;
  endfunction : ptr_dec

endpackage : rfb_pkg

// file: design/rfb_ram.sv
// Purpose: word store of the receive frame buffer, built from flip-flops
// Assumes: addresses already wrapped below DEPTH
// Notes:   one write port, one combinational read port

`timescale 1ns/10ps
`default_nettype none

module rfb_ram #(
  parameter int DEPTH = rfb_pkg::DEPTH_DEF
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     we,
  input  wire rfb_pkg::rfb_ptr_type     waddr,
  input  wire logic [rfb_pkg::DW-1:0]   wdata,
  input  wire rfb_pkg::rfb_ptr_type     raddr,
  output logic [rfb_pkg::DW-1:0]        rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][rfb_pkg::DW-1:0] mem;
  } rfb_ram_state_type;

  rfb_ram_state_type q_r;
  rfb_ram_state_type q_nxt;

  // single write per cycle, producer never writes two words at once
  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rdata = q_r.mem[raddr];

endmodule : rfb_ram

`default_nettype wire

// file: design/rfb_top.sv
// Purpose: receive frame FIFO, stores frames word by word as they arrive
// Assumes: producer commands are single-cycle pulses, already filtered
// Notes:   a frame becomes readable only after its commit

`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1: RAM depth is a build parameter from 32 to 4096 words of 32 bits.
// RL2: each stored frame occupies between 4 and 20 RAM words.
// RL3: a frame without data takes 4 words: metadata, identifier, two stamps.
// RL4: every further group of 4 payload bytes takes one more word.
// RL5: raw write pointer steps by one on every header or data word written; the two stamp writes leave it in place.
// RL6: raw pointer reloads from committed on abort or on valid after overflow.
// RL7: commit copies raw pointer into committed pointer, frame becomes visible.
// RL8: stamp pointer loads at lower stamp word, steps while lower stamp stored.
// RL9: read pointer steps by one per word read.
// RL10: release command zeroes every pointer and the stored-frame counter.
// RL11: release during storing sets overrun and drops that frame at its end.
// RL12: a count of complete frames follows commits and reads.
// RL13: storing is abandoned on error frame request or overrun.
// RL14: a read port hands stored words to the register side.
// RL15: store-metadata writes four header words in four consecutive cycles.
// RL16: producer sends valid at the last end-of-frame bit; stamp then commit.
// RL17: a frame still being stored cannot be read.
// RL18: producer sends store-data per 4 payload bytes and at data end.
// RL19: a write that would overtake the reader is dropped and flags overflow.
// RL20: all pointers wrap modulo the RAM depth.
module rfb_top #(
  parameter int DEPTH = rfb_pkg::DEPTH_DEF
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     cmd_store_meta,
  input  wire logic                     cmd_store_data,
  input  wire logic                     cmd_rx_valid,
  input  wire logic                     cmd_rx_abort,
  input  wire logic [rfb_pkg::DW-1:0]   meta_word,
  input  wire logic [rfb_pkg::DW-1:0]   ident_word,
  input  wire logic [rfb_pkg::DW-1:0]   data_word,
  input  wire logic [63:0]              timestamp,
  input  wire logic                     release_rx_store_cmd,
  input  wire logic                     clr_overrun,
  input  wire logic                     rd_strobe,
  output logic [rfb_pkg::DW-1:0]        rd_data,
  output logic                          rd_valid,
  output rfb_pkg::rfb_cnt_type          frame_count,
  output logic                          overrun,
  output logic                          storing
);

  typedef struct packed {
    rfb_pkg::rfb_state_type st;
    logic [1:0]             step;
    rfb_pkg::rfb_ptr_type   raw;
    rfb_pkg::rfb_ptr_type   cmt;
    rfb_pkg::rfb_ptr_type   ts;
    rfb_pkg::rfb_ptr_type   rd;
    rfb_pkg::rfb_cnt_type   cnt_raw;
    rfb_pkg::rfb_cnt_type   cnt_cmt;
    rfb_pkg::rfb_cnt_type   frames;
    logic [rfb_pkg::WCNT_W-1:0] left;
    logic                   ovf;
    logic                   overrun;
    logic [rfb_pkg::DW-1:0] hold;
    logic [rfb_pkg::DW-1:0] rd_data;
    logic                   rd_valid;
    logic                   busy;
  } rfb_top_state_type;

  // depth is the only shape knob; pointers are sized for the maximum
  localparam rfb_pkg::rfb_ptr_type LAST = rfb_pkg::rfb_ptr_type'(DEPTH - 1);  // see RL1
  localparam rfb_pkg::rfb_cnt_type CAP  = rfb_pkg::rfb_cnt_type'(DEPTH);

  rfb_top_state_type      q_r;
  rfb_top_state_type      q_nxt;
  logic                   ram_we;
  rfb_pkg::rfb_ptr_type   ram_waddr;
  logic [rfb_pkg::DW-1:0] ram_wdata;
  logic [rfb_pkg::DW-1:0] ram_rdata;
  logic                   raw_wr;
  logic [rfb_pkg::WCNT_W-1:0] wcnt;
  logic                   frame_done;

  rfb_ram #(
    .DEPTH (DEPTH)
  ) u_ram (
    .clock (clock),
    .rst   (rst),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (q_r.rd),
    .rdata (ram_rdata)
  );

  // next state: reads, then the store sequence, then writes, release last
  always_comb begin
    q_nxt = q_r;
    q_nxt.rd_valid = 1'b0;
    q_nxt.overrun = q_r.overrun & ~clr_overrun;  // any set below wins
    ram_we = 1'b0;
    ram_waddr = q_r.raw;
    ram_wdata = rfb_pkg::WORD_ZERO;
    raw_wr = 1'b0;
    wcnt = ram_rdata[rfb_pkg::WCNT_LSB +: rfb_pkg::WCNT_W];
    frame_done = 1'b0;

    // only committed words are offered to the reader
    if (rd_strobe && (q_r.cnt_cmt != rfb_pkg::CNT_RST)) begin  // see RL17
      q_nxt.rd_data = ram_rdata;  // see RL14
      q_nxt.rd_valid = 1'b1;
      q_nxt.rd = rfb_pkg::ptr_inc(q_r.rd, LAST);  // see RL9, see RL20
      q_nxt.cnt_cmt = q_r.cnt_cmt - 13'h0001;
      q_nxt.cnt_raw = q_r.cnt_raw - 13'h0001;
      // metadata word tells how many words of the frame follow it
      if (q_r.left == '0) begin
        q_nxt.left = wcnt;
        frame_done = (wcnt == '0);
      end else begin
        q_nxt.left = q_r.left - 5'h01;
        frame_done = (q_r.left == 5'h01);
      end
      if (frame_done) begin
        q_nxt.frames = q_r.frames - 13'h0001;  // see RL12
      end
    end

    case (q_r.st)
      rfb_pkg::ST_IDLE: begin
        // metadata goes in the command cycle itself, identifier is held
        if (cmd_store_meta) begin
          raw_wr = 1'b1;  // see RL15, see RL3
          ram_wdata = meta_word;
          q_nxt.hold = ident_word;
          q_nxt.step = rfb_pkg::STEP_IDENT;
          q_nxt.ovf = 1'b0;
          q_nxt.st = rfb_pkg::ST_META;
        end
      end
      rfb_pkg::ST_META: begin
        if (cmd_rx_abort) begin
          q_nxt.raw = q_r.cmt;  // see RL6, see RL13
          q_nxt.cnt_raw = q_nxt.cnt_cmt;
          q_nxt.st = rfb_pkg::ST_IDLE;
        end else begin
          raw_wr = 1'b1;  // see RL15
          ram_wdata = (q_r.step == rfb_pkg::STEP_IDENT) ? q_r.hold : rfb_pkg::WORD_ZERO;
          q_nxt.step = q_r.step + 2'h1;
          if (q_r.step == rfb_pkg::STEP_TS_LO) begin
            q_nxt.ts = q_r.raw;  // see RL8
            q_nxt.st = rfb_pkg::ST_STORE;
          end
        end
      end
      rfb_pkg::ST_STORE: begin
        if (cmd_rx_abort) begin
          q_nxt.raw = q_r.cmt;  // see RL6, see RL13
          q_nxt.cnt_raw = q_nxt.cnt_cmt;
          q_nxt.st = rfb_pkg::ST_IDLE;
        end else if (cmd_rx_valid) begin
          if (q_r.ovf) begin
            // part of the frame was dropped, so none of it is kept
            q_nxt.raw = q_r.cmt;  // see RL6, see RL11, see RL13
            q_nxt.cnt_raw = q_nxt.cnt_cmt;
            q_nxt.st = rfb_pkg::ST_IDLE;
          end else begin
            // upper stamp sits just below the lower one
            ram_we = 1'b1;  // see RL16
            ram_waddr = rfb_pkg::ptr_dec(q_r.ts, LAST);
            ram_wdata = timestamp[63:32];
            q_nxt.hold = timestamp[31:0];
            q_nxt.st = rfb_pkg::ST_TS_LO;
          end
        end else if (cmd_store_data) begin
          raw_wr = 1'b1;  // see RL4, see RL2
          ram_wdata = data_word;
        end
      end
      rfb_pkg::ST_TS_LO: begin
        ram_we = 1'b1;
        ram_waddr = q_r.ts;
        ram_wdata = q_r.hold;
        q_nxt.ts = rfb_pkg::ptr_inc(q_r.ts, LAST);  // see RL8
        q_nxt.cmt = q_r.raw;  // see RL7
        q_nxt.cnt_cmt = q_nxt.cnt_raw;
        q_nxt.frames = q_nxt.frames + 13'h0001;  // see RL12
        q_nxt.st = rfb_pkg::ST_IDLE;
      end
      default: begin
        q_nxt.st = rfb_pkg::ST_IDLE;
      end
    endcase

    // a full ring drops the word instead of overwriting unread data
    if (raw_wr) begin
      if (q_r.cnt_raw < CAP) begin
        ram_we = 1'b1;
        ram_waddr = q_r.raw;
        q_nxt.raw = rfb_pkg::ptr_inc(q_r.raw, LAST);  // see RL5, see RL20
        q_nxt.cnt_raw = q_nxt.cnt_raw + 13'h0001;
      end else begin
        q_nxt.ovf = 1'b1;  // see RL19
        q_nxt.overrun = 1'b1;
      end
    end

    // flush; a frame in flight is marked bad and dropped when it ends
    if (release_rx_store_cmd) begin
      q_nxt.raw = rfb_pkg::PTR_RST;  // see RL10
      q_nxt.cmt = rfb_pkg::PTR_RST;
      q_nxt.ts = rfb_pkg::PTR_RST;
      q_nxt.rd = rfb_pkg::PTR_RST;
      q_nxt.cnt_raw = rfb_pkg::CNT_RST;
      q_nxt.cnt_cmt = rfb_pkg::CNT_RST;
      q_nxt.frames = rfb_pkg::CNT_RST;
      q_nxt.left = '0;
      // a frame caught in its commit cycle is wiped as well, so it is flagged too
      if ((q_nxt.st != rfb_pkg::ST_IDLE) || q_r.busy) begin
        q_nxt.ovf = 1'b1;  // see RL11
        q_nxt.overrun = 1'b1;
      end
    end

    q_nxt.busy = (q_nxt.st != rfb_pkg::ST_IDLE);
  end

  // state register, constants only under reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.st <= rfb_pkg::ST_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs are plain flop fields
  assign rd_data = q_r.rd_data;
  assign rd_valid = q_r.rd_valid;
  assign frame_count = q_r.frames;
  assign overrun = q_r.overrun;
  assign storing = q_r.busy;

endmodule : rfb_top

`default_nettype wire

// file: test/rfb_top_assertions.sv
// Purpose: port-level checks of the receive frame store
// Assumes: one clock, rst asynchronous and active high
// Notes:   bound into rfb_top, watches design inputs and outputs
`timescale 1ns/10ps
`default_nettype none
module rfb_chk #(
  parameter int DEPTH = 32
) (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic                 cmd_store_meta,
  input wire logic                 cmd_rx_valid,
  input wire logic                 cmd_rx_abort,
  input wire logic                 release_rx_store_cmd,
  input wire logic                 clr_overrun,
  input wire logic                 rd_strobe,
  input wire logic                 rd_valid,
  input wire rfb_pkg::rfb_cnt_type frame_count,
  input wire logic                 overrun,
  input wire logic                 storing
);
  // single domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic rel;
  assign rel = release_rx_store_cmd;

  a_read_answer: assert property (rd_valid |-> $past(rd_strobe))
    else $error("read answer without strobe");
  a_store_start: assert property (
    (cmd_store_meta && !storing && !rel && !cmd_rx_abort) |=> storing)
    else $error("storing did not rise after store start");
  a_abort_stop: assert property (
    (cmd_rx_abort && storing && !cmd_store_meta) |=> !storing)
    else $error("storing still high after abort");
  a_release_zero: assert property (rel |=> frame_count == 13'h0000)
    else $error("frame count not zero after release");
  a_release_ovr: assert property ((rel && storing) |=> overrun)
    else $error("overrun not set by release while storing");
  // reads are kept out of the window so the count can only climb
  a_commit_count: assert property (
    (cmd_rx_valid && storing && !overrun && !rel && !rd_strobe)
    ##1 (!rel && !rd_strobe) |=> frame_count == $past(frame_count, 2) + 13'h0001)
    else $error("commit did not add one frame");
  a_count_drop: assert property (
    (frame_count < $past(frame_count)) |-> (rd_valid || $past(rel)))
    else $error("frame count fell without read or release");
  a_empty_read: assert property (
    (rd_strobe && frame_count == 13'h0000 && !rel) |=> !rd_valid)
    else $error("read answered with no committed frame");
  a_overrun_hold: assert property ($fell(overrun) |-> $past(clr_overrun))
    else $error("overrun fell without clear");

  c_commit: cover property (cmd_rx_valid && storing ##2 frame_count != 13'h0000);
  c_read: cover property (rd_valid);
  c_rel_store: cover property (rel && storing);
endmodule : rfb_chk
bind rfb_top rfb_chk #(.DEPTH(DEPTH)) chk (.clock, .rst, .cmd_store_meta, .cmd_rx_valid,
  .cmd_rx_abort, .release_rx_store_cmd, .clr_overrun, .rd_strobe, .rd_valid, .frame_count,
  .overrun, .storing);
`default_nettype wire

// file: test/rfb_producer.sv
// Purpose: behavioural frame producer issuing storing commands
// Assumes: commands are one-cycle pulses launched after a rising edge
// Notes:   word lines show inverted values once a pulse is over
`timescale 1ns/10ps
`default_nettype none
module rfb_producer (
  input  wire logic  clock,
  output logic       cmd_store_meta,
  output logic       cmd_store_data,
  output logic       cmd_rx_valid,
  output logic       cmd_rx_abort,
  output logic [31:0] meta_word,
  output logic [31:0] ident_word,
  output logic [31:0] data_word,
  output logic [63:0] timestamp
);
  // quiet bus at time zero
  initial begin
    {cmd_store_meta, cmd_store_data, cmd_rx_valid, cmd_rx_abort} = 4'h0;
    {meta_word, ident_word, data_word} = 96'h0;
    timestamp = 64'h0;
  end
  // header, n data words, then valid (fin 0) or abort (fin 1)
  task automatic frame(input int n, input logic fin);
    int k;
    @(posedge clock);
    cmd_store_meta <= 1'b1;
    meta_word      <= 32'hA5000003 + n;
    ident_word     <= 32'h10000000 + n;
    @(posedge clock);
    cmd_store_meta <= 1'b0;
    meta_word      <= ~meta_word;
    ident_word     <= ~ident_word;
    repeat (3) @(posedge clock);
    for (k = 0; k < n; k++) begin
      cmd_store_data <= 1'b1;
      data_word      <= 32'hD0000000 + (n << 8) + k;
      @(posedge clock);
    end
    cmd_store_data <= 1'b0;
    data_word      <= ~data_word;
    cmd_rx_valid   <= !fin;
    cmd_rx_abort   <= fin;
    timestamp      <= 64'h1122334455667788 + n;
    @(posedge clock);
    {cmd_rx_valid, cmd_rx_abort} <= 2'h0;
    timestamp <= ~timestamp;
    // storing needs two edges to fall before the next start
    repeat (2) @(posedge clock);
  endtask : frame
endmodule : rfb_producer
`default_nettype wire

// file: test/rfb_top_bench.sv
// Purpose: self-checking bench of the receive frame store
// Assumes: DEPTH 32, inputs driven by NBA at rising edges
// Notes:   expected words rebuilt from the producer's patterns
`timescale 1ns/10ps
`default_nettype none
module rfb_top_bench;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 release_rx_store_cmd = 1'b0;
  logic                 clr_overrun = 1'b0;
  logic                 rd_strobe = 1'b0;
  logic                 cmd_store_meta, cmd_store_data, cmd_rx_valid, cmd_rx_abort;
  logic [31:0]          meta_word, ident_word, data_word, rd_data;
  logic [63:0]          timestamp;
  logic                 rd_valid, overrun, storing;
  rfb_pkg::rfb_cnt_type frame_count;
  int                   n_errors = 0;
  int                   check_count = 0;

  always #20 clock = ~clock;
  rfb_producer prod (.clock, .cmd_store_meta, .cmd_store_data, .cmd_rx_valid, .cmd_rx_abort,
    .meta_word, .ident_word, .data_word, .timestamp);
  rfb_top #(.DEPTH(32)) dut (.clock, .rst, .cmd_store_meta, .cmd_store_data, .cmd_rx_valid,
    .cmd_rx_abort, .meta_word, .ident_word, .data_word, .timestamp, .release_rx_store_cmd,
    .clr_overrun, .rd_strobe, .rd_data, .rd_valid, .frame_count, .overrun, .storing);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // one strobe; v says whether a word must come back
  task automatic rd(input logic v, input logic [31:0] exp);
    @(posedge clock);
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    check("rd_valid", {31'h0, rd_valid}, {31'h0, v});
    if (v) check("rd_data", rd_data, exp);
  endtask : rd
  task automatic rd_frame(input int n);
    logic [63:0] ts;
    int          k;
    ts = 64'h1122334455667788 + n;
    rd(1'b1, 32'hA5000003 + n);
    rd(1'b1, 32'h10000000 + n);
    rd(1'b1, ts[63:32]);
    rd(1'b1, ts[31:0]);
    for (k = 0; k < n; k++) begin
      rd(1'b1, 32'hD0000000 + (n << 8) + k);
    end
  endtask : rd_frame
  task automatic cnt(input logic [12:0] exp);
    check("frame_count", {19'h0, frame_count}, {19'h0, exp});
  endtask : cnt
  // rel 1 pulses the flush, rel 0 the overrun clear
  task automatic poke(input logic rel);
    @(posedge clock);
    release_rx_store_cmd <= rel;
    clr_overrun          <= !rel;
    @(posedge clock);
    release_rx_store_cmd <= 1'b0;
    clr_overrun          <= 1'b0;
    #1;
  endtask : poke

  task automatic t_empty();
    cnt(13'h0000);
    check("storing", {31'h0, storing}, 32'h0);
    rd(1'b0, 32'h0);
  endtask : t_empty
  task automatic t_frames();
    prod.frame(0, 1'b0);
    #1 cnt(13'h0001);
    prod.frame(3, 1'b0);
    #1 cnt(13'h0002);
    rd_frame(0);
    cnt(13'h0001);
    rd_frame(3);
    cnt(13'h0000);
  endtask : t_frames
  // uncommitted words stay hidden, abort rolls the writer back
  task automatic t_abort();
    fork
      prod.frame(2, 1'b1);
      begin
        repeat (4) @(posedge clock);
        rd(1'b0, 32'h0);
      end
    join
    #1 check("storing", {31'h0, storing}, 32'h0);
    prod.frame(1, 1'b0);
    rd_frame(1);
  endtask : t_abort
  task automatic t_release();
    fork
      prod.frame(2, 1'b0);
      begin
        repeat (5) @(posedge clock);
        poke(1'b1);
        check("overrun", {31'h0, overrun}, 32'h1);
      end
    join
    #1 cnt(13'h0000);
    poke(1'b0);
    check("overrun", {31'h0, overrun}, 32'h0);
    prod.frame(0, 1'b0);
    rd_frame(0);
  endtask : t_release
  // second long frame cannot fit, third one wraps the ring
  task automatic t_overflow();
    prod.frame(16, 1'b0);
    prod.frame(16, 1'b0);
    #1 check("overrun", {31'h0, overrun}, 32'h1);
    cnt(13'h0001);
    rd_frame(16);
    poke(1'b0);
    prod.frame(16, 1'b0);
    rd_frame(16);
    cnt(13'h0000);
  endtask : t_overflow

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_empty();
    t_frames();
    t_abort();
    t_release();
    t_overflow();
    close_out();
  end
endmodule : rfb_top_bench
`default_nettype wire
